// ### tb_top.sv
// Testbench joining endpoint logic and DMA engine, driven over AXI4-Lite
`timescale 1ns/1ps
module tb_top import usb_dma_pkg::*;;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  aa = 8'h00, ra = 8'h00, rb = 8'h00, mrd = 8'h00, tbyte, mwd;
  logic        av = 1'b0, wv = 1'b0, bb = 1'b0, arv = 1'b0, rr = 1'b0;
  logic        tp = 1'b0, rp = 1'b0, re = 1'b0, cv = 1'b0;
  logic        awr, wrr, bv, arr, rv, irq, mreq, mwe;
  logic [31:0] wd = 32'h0, cad = 32'h0, rdat, ma;
  logic [1:0]  br, rrs, rpe = 2'h0;
  logic [2:0]  tpd = 3'h0, cc = 3'h0, ue = 3'h0, tps, room;
  logic [15:0] cnt = 16'h0;
  logic [5:0]  ca;
  logic [7:0]  mem [256];
  int          miscompares = 0, cmp_count = 0, starts = 0;

  usb_dma_if bus();
  usb_ep_dma usb_ep_dma_i(.clk(clk), .reset(reset), .dma(bus),
    .s_axi_awaddr(aa), .s_axi_awvalid(av), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bb), .s_axi_araddr(ra), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rrs), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .usb_irq(irq), .tx_pkt_start(tps), .tx_pop(tp), .tx_pop_ep(2'h1),
    .tx_byte(tbyte), .tx_pkt_done(tpd), .usb_err(ue), .rx_push(rp), .rx_push_ep(rpe),
    .rx_byte(rb), .rx_end(re), .rx_short(re), .rx_room(room));
  usb_dma_engine usb_dma_engine_i(.clk(clk), .reset(reset), .usb(bus), .cfg_valid(cv),
    .cfg_chan(cc), .cfg_addr(cad), .cfg_count(cnt), .cfg_burst(1'b1), .cfg_enable(1'b1),
    .chan_active(ca), .mem_req(mreq), .mem_we(mwe), .mem_addr(ma), .mem_wdata(mwd),
    .mem_rdata(mrd));
  usb_dma_assertions usb_dma_assertions_i(.clk(clk), .reset(reset), .tx_req(bus.tx_req),
    .rx_req(bus.rx_req), .rd_data(bus.rd_data), .rd_valid(bus.rd_valid), .burst(bus.burst),
    .wr_valid(bus.wr_valid), .wr_ep(bus.wr_ep), .wr_data(bus.wr_data),
    .rd_strobe(bus.rd_strobe), .rd_ep(bus.rd_ep), .done_valid(bus.done_valid),
    .done_ep(bus.done_ep), .done_tx(bus.done_tx));

  always #50 clk = ~clk;

  // ****************
  // System memory and pulse monitor
  // ****************
  always @(posedge clk) begin
    if (mreq && mwe) mem[ma[7:0]] <= mwd;
    if (mreq && !mwe) mrd <= mem[ma[7:0]];
    if (tps[0]) starts <= starts + 1;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // Address and data are offered together and released at the edge that takes them
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    aa <= a;
    wd <= d;
    av <= 1'b1;
    wv <= 1'b1;
    bb <= 1'b1;
    do @(negedge clk); while (!(awr && wrr));
    @(posedge clk);
    av <= 1'b0;
    wv <= 1'b0;
    do @(negedge clk); while (!bv);
    chk(32'(br), 32'(er));
    @(posedge clk);
    bb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    ra <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do @(negedge clk); while (!arr);
    @(posedge clk);
    arv <= 1'b0;
    do @(negedge clk); while (!rv);
    chk(rdat, ed);
    chk(32'(rrs), 32'(er));
    @(posedge clk);
    rr <= 1'b0;
  endtask

  task automatic dma(input logic [2:0] ch, input logic [31:0] a, input logic [15:0] n);
    @(posedge clk);
    cv <= 1'b1;
    cc <= ch;
    cad <= a;
    cnt <= n;
    @(posedge clk);
    cv <= 1'b0;
    do @(negedge clk); while (ca[ch]);
  endtask

  task automatic push(input logic [1:0] ep, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rp <= 1'b1;
      rpe <= ep;
      rb <= 8'ha0 + 8'(i);
      re <= (i == n - 1);
    end
    @(posedge clk);
    rp <= 1'b0;
    re <= 1'b0;
  endtask

  // One-cycle bus-side packet-sent and error pulses
  task automatic pulse(input logic [2:0] d, input logic [2:0] e);
    @(posedge clk);
    tpd <= d;
    ue  <= e;
    @(posedge clk);
    tpd <= 3'h0;
    ue  <= 3'h0;
  endtask

  task automatic irq_is(input logic e);
    @(negedge clk);
    chk(32'(irq), 32'(e));
  endtask

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ****************
  // Tests
  // ****************
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(CTRL_OFF, CTRL_RST, RESP_OKAY);
    rd(MASK_OFF, MASK_RST, RESP_OKAY);
    rd(STATUS_OFF, STATUS_RST, RESP_OKAY);
    rd(8'h20, 32'h0, RESP_SLVERR);
    wr(STATE_OFF, 32'h1, RESP_SLVERR);
    $display("test registers done");
    wr(MASK_OFF, 32'h707, RESP_OKAY);
    wr(CTRL_OFF, 32'h17, RESP_OKAY);
    rd(STATE_OFF, 32'h1, RESP_OKAY);
    dma(3'h1, 32'h0, 16'h4);
    // Arming trails the done pulse by two edges
    repeat (3) @(negedge clk);
    chk(32'(starts), 32'h1);
    rd(STATUS_OFF, 32'h1, RESP_OKAY);
    irq_is(1'b1);
    wr(MASK_OFF, 32'h0, RESP_OKAY);
    irq_is(1'b0);
    rd(STATUS_OFF, 32'h1, RESP_OKAY);
    wr(MASK_OFF, 32'h707, RESP_OKAY);
    wr(STATUS_OFF, 32'h1, RESP_OKAY);
    rd(STATUS_OFF, 32'h0, RESP_OKAY);
    irq_is(1'b0);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      tp <= 1'b1;
      @(posedge clk);
      tp <= 1'b0;
      @(negedge clk);
      chk(32'(tbyte), 32'(8'(i) ^ 8'h5a));
    end
    pulse(3'h1, 3'h0);
    rd(STATUS_OFF, 32'h1, RESP_OKAY);
    rd(STATE_OFF, 32'h1, RESP_OKAY);
    wr(STATUS_OFF, 32'h1, RESP_OKAY);
    $display("test transmit done");
    wr(CTRL_OFF, 32'h2917, RESP_OKAY);
    push(2'h2, 3);
    rd(STATUS_OFF, 32'h200, RESP_OKAY);
    rd(STATE_OFF, 32'h201, RESP_OKAY);
    @(negedge clk);
    chk(32'(room[1]), 32'h0);
    wr(STATUS_OFF, 32'h200, RESP_OKAY);
    dma(3'h2, 32'h80, 16'h3);
    for (int i = 0; i < 3; i++) chk(32'(mem[8'h80 + 8'(i)]), 32'(8'ha0 + 8'(i)));
    rd(STATUS_OFF, 32'h200, RESP_OKAY);
    @(negedge clk);
    chk(32'(room[1]), 32'h1);
    wr(STATUS_OFF, 32'h200, RESP_OKAY);
    wr(CTRL_OFF, 32'h21_2917, RESP_OKAY);
    push(2'h3, 2);
    rd(STATUS_OFF, 32'h0, RESP_OKAY);
    $display("test receive done");
    // An error raises both event bits of its endpoint
    pulse(3'h0, 3'h4);
    rd(STATUS_OFF, 32'h404, RESP_OKAY);
    wr(STATUS_OFF, 32'h404, RESP_OKAY);
    pulse(3'h1, 3'h0);
    rd(STATUS_OFF, 32'h0, RESP_OKAY);
    wr(CTRL_OFF, 32'h21_2913, RESP_OKAY);
    pulse(3'h1, 3'h0);
    rd(STATUS_OFF, 32'h1, RESP_OKAY);
    $display("test packet interrupts done");
    give_verdict();
  end

  // Whole run needs a few hundred cycles; a stuck handshake ends here
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    give_verdict();
  end
endmodule // tb_top

// ### usb_dma_assertions.sv
// Concurrent checks on the link between endpoint FIFOs and the DMA engine
`timescale 1ns/1ps
module usb_dma_assertions import usb_dma_pkg::*; (
  input wire logic              clk,
  input wire logic              reset,
  input wire logic [NUM_EP-1:0] tx_req,
  input wire logic [NUM_EP-1:0] rx_req,
  input wire logic [7:0]        rd_data,
  input wire logic              rd_valid,
  input wire logic              burst,
  input wire logic              wr_valid,
  input wire logic [EP_W-1:0]   wr_ep,
  input wire logic [7:0]        wr_data,
  input wire logic              rd_strobe,
  input wire logic [EP_W-1:0]   rd_ep,
  input wire logic              done_valid,
  input wire logic [EP_W-1:0]   done_ep,
  input wire logic              done_tx
);
  // ****************
  // Link properties
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_wr_ep_nonzero:
    assert property (wr_valid |-> wr_ep != 2'h0) else $error("dma write to endpoint zero");
  a_rd_ep_nonzero:
    assert property (rd_strobe |-> rd_ep != 2'h0) else $error("dma read of endpoint zero");
  a_burst_used:
    assert property ((wr_valid || rd_strobe) |-> burst) else $error("access without burst");
  a_rd_answer:
    assert property (rd_strobe && burst && rd_ep != 2'h0 && rx_req[rd_ep - 2'h1] |=> rd_valid)
      else $error("receive read not answered");
  a_tx_done_src:
    assert property (done_valid && done_tx |-> $past(wr_valid) && $past(wr_ep) == done_ep)
      else $error("transmit done without last write");
  a_rx_done_src:
    assert property (done_valid && !done_tx |-> $past(rd_valid) && $past(rd_ep, 2) == done_ep)
      else $error("receive done without last read");
  a_done_pulse:
    assert property (done_valid |=> !done_valid) else $error("done longer than one cycle");
  a_wr_needs_req:
    assert property (wr_valid |-> |$past(tx_req)) else $error("write with no transmit request");
endmodule // usb_dma_assertions

// ### usb_dma_engine.sv
// Micro DMA controller end: six channels moving bytes to and from endpoint FIFOs
`timescale 1ns/1ps
module usb_dma_engine import usb_dma_pkg::*; #(
  parameter int ARB = ARB_SIZE
) (
  input  wire logic              clk,
  input  wire logic              reset,
  usb_dma_if.dma_end             usb,
  input  wire logic              cfg_valid,
  input  wire logic [2:0]        cfg_chan,
  input  wire logic [31:0]       cfg_addr,
  input  wire logic [CNT_W-1:0]  cfg_count,
  input  wire logic              cfg_burst,
  input  wire logic              cfg_enable,
  output logic      [CHANS-1:0]  chan_active,
  output logic                   mem_req,
  output logic                   mem_we,
  output logic      [31:0]       mem_addr,
  output logic      [7:0]        mem_wdata,
  input  wire logic [7:0]        mem_rdata
);
  dma_state_e       state_reg;
  logic [2:0]       cur_reg;
  logic [CNT_W-1:0] beat_reg;
  logic [31:0]      addr_reg  [CHANS];
  logic [CNT_W-1:0] cnt_reg   [CHANS];
  logic [CHANS-1:0] en_reg;
  logic [CHANS-1:0] burst_reg;
  logic [CHANS-1:0] req;
  logic             done_valid_reg;
  logic [EP_W-1:0]  done_ep_reg;
  logic             done_tx_reg;
  logic             pick_ok;
  logic [2:0]       pick;

  // Channel index is twice the endpoint index plus one for transmit
  genvar c;
  for (c = 0; c < CHANS; c++) begin : g_req
    if (c % 2 == 1) begin : g_tx
      assign req[c] = usb.tx_req[c/2];
    end else begin : g_rx
      assign req[c] = usb.rx_req[c/2];
    end
    assign chan_active[c] = en_reg[c];
  end

  always_comb begin
    pick_ok = 1'b0;
    pick    = 3'h0;
    for (int k = CHANS - 1; k >= 0; k--) begin
      if (en_reg[k] && req[k] && cnt_reg[k] != '0) begin
        pick_ok = 1'b1;
        pick    = 3'(k);
      end
    end
  end

  wire cur_tx = cur_reg[0];
  wire cur_req = req[cur_reg];

  // ****************************************
  // Transfer sequencing
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= DMA_IDLE;
      cur_reg   <= 3'h0;
      beat_reg  <= '0;
    end else begin
      unique case (state_reg)
        DMA_IDLE: begin
          if (pick_ok) begin
            cur_reg   <= pick;
            beat_reg  <= '0;
            state_reg <= DMA_FETCH;
          end
        end
        DMA_FETCH: begin
          // Endpoint withdrew its request: burst ends, wait for the next
          state_reg <= cur_req ? DMA_MOVE : DMA_IDLE;
        end
        DMA_MOVE: begin
          beat_reg <= beat_reg + 1'b1;
          if (cnt_reg[cur_reg] == CNT_W'(1) || beat_reg == CNT_W'(ARB - 1)) begin
            state_reg <= DMA_IDLE;
          end else begin
            state_reg <= DMA_FETCH;
          end
        end
        default: state_reg <= DMA_IDLE;
      endcase
    end
  end

  // ****************************************
  // Channel registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      en_reg    <= '0;
      burst_reg <= '0;
      for (int k = 0; k < CHANS; k++) begin
        addr_reg[k] <= 32'h0;
        cnt_reg[k]  <= '0;
      end
    end else begin
      if (state_reg == DMA_MOVE) begin
        // Memory side steps one byte, FIFO side stays fixed
        addr_reg[cur_reg] <= addr_reg[cur_reg] + 32'(DST_INC);
        cnt_reg[cur_reg]  <= cnt_reg[cur_reg] - 1'b1;
        if (cnt_reg[cur_reg] == CNT_W'(1)) begin
          en_reg[cur_reg] <= 1'b0;
        end
      end
      // A finished channel sleeps until reloaded and enabled again
      if (cfg_valid && cfg_chan < 3'(CHANS)) begin
        addr_reg[cfg_chan]  <= cfg_addr;
        cnt_reg[cfg_chan]   <= cfg_count;
        burst_reg[cfg_chan] <= cfg_burst;
        en_reg[cfg_chan]    <= cfg_enable;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      done_valid_reg <= 1'b0;
      done_ep_reg    <= '0;
      done_tx_reg    <= 1'b0;
    end else begin
      done_valid_reg <= state_reg == DMA_MOVE && cnt_reg[cur_reg] == CNT_W'(1);
      done_ep_reg    <= EP_W'(cur_reg[2:1] + 2'h1);
      done_tx_reg    <= cur_tx;
    end
  end

  assign usb.burst      = burst_reg[cur_reg];
  assign usb.rd_strobe  = state_reg == DMA_FETCH && cur_req && !cur_tx;
  assign usb.rd_ep      = EP_W'(cur_reg[2:1] + 2'h1);
  assign usb.wr_valid   = state_reg == DMA_MOVE && cur_tx;
  assign usb.wr_ep      = EP_W'(cur_reg[2:1] + 2'h1);
  assign usb.wr_data    = mem_rdata;
  assign usb.done_valid = done_valid_reg;
  assign usb.done_ep    = done_ep_reg;
  assign usb.done_tx    = done_tx_reg;
  // Receive items are single bytes read from the fixed FIFO port
  assign mem_req   = (state_reg == DMA_FETCH && cur_req && cur_tx) ||
                     (state_reg == DMA_MOVE && !cur_tx);
  assign mem_we    = state_reg == DMA_MOVE && !cur_tx;
  assign mem_addr  = addr_reg[cur_reg];
  assign mem_wdata = usb.rd_data;
endmodule // usb_dma_engine

// ### usb_dma_if.sv
// Link between endpoint FIFOs and the micro DMA controller
`timescale 1ns/1ps
interface usb_dma_if;
  import usb_dma_pkg::*;
  logic [NUM_EP-1:0] tx_req;
  logic [NUM_EP-1:0] rx_req;
  logic [7:0]        rd_data;
  logic              rd_valid;
  logic              burst;
  logic              wr_valid;
  logic [EP_W-1:0]   wr_ep;
  logic [7:0]        wr_data;
  logic              rd_strobe;
  logic [EP_W-1:0]   rd_ep;
  logic              done_valid;
  logic [EP_W-1:0]   done_ep;
  logic              done_tx;

  modport usb_end (
    output tx_req, rx_req, rd_data, rd_valid,
    input  burst, wr_valid, wr_ep, wr_data, rd_strobe, rd_ep, done_valid, done_ep, done_tx
  );
  modport dma_end (
    input  tx_req, rx_req, rd_data, rd_valid,
    output burst, wr_valid, wr_ep, wr_data, rd_strobe, rd_ep, done_valid, done_ep, done_tx
  );
endinterface // usb_dma_if

// ### usb_dma_pkg.sv
// Shared constants for the endpoint DMA service logic and its DMA engine
package usb_dma_pkg;
  localparam int NUM_EP     = 3;
  localparam int EP_W       = 2;
  localparam int CHANS      = 2 * NUM_EP;
  localparam int FIFO_DEPTH = 64;
  localparam int MAX_PKT    = 64;
  localparam int ARB_SIZE   = 64;
  localparam int ITEM_BITS  = 8;
  localparam int SRC_INC    = 0;
  localparam int DST_INC    = 1;
  localparam int ADDR_W     = 8;
  localparam int CNT_W      = 16;

  localparam logic [ADDR_W-1:0] CTRL_OFF   = 8'h00;
  localparam logic [ADDR_W-1:0] CMD_OFF    = 8'h04;
  localparam logic [ADDR_W-1:0] STATUS_OFF = 8'h08;
  localparam logic [ADDR_W-1:0] MASK_OFF   = 8'h0c;
  localparam logic [ADDR_W-1:0] STATE_OFF  = 8'h10;

  localparam int CTRL_EP_STRIDE = 8;
  localparam int DMA_EN_BIT     = 0;
  localparam int DIR_IN_BIT     = 1;
  localparam int TX_MODE_BIT    = 2;
  localparam int RX_MODE_BIT    = 3;
  localparam int AUTO_ARM_BIT   = 4;
  localparam int AUTO_ACK_BIT   = 5;
  localparam int HOST_MODE_BIT  = 24;
  localparam int CMD_ARM_POS    = 0;
  localparam int CMD_ACK_POS    = 8;
  localparam int INT_TX_POS     = 0;
  localparam int INT_RX_POS     = 8;
  localparam int ST_TXREQ_POS   = 0;
  localparam int ST_RXREQ_POS   = 8;
  localparam int ST_ARMED_POS   = 16;

  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] MASK_RST   = 32'h0000_0000;
  localparam logic [31:0] STATUS_RST = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Per-packet interrupt setting is 0, completion-only setting is 1
  localparam logic DMA_PER_PACKET_IRQ_SETTING = 1'b0;
  localparam logic DMA_COMPLETION_IRQ_SETTING = 1'b1;

  typedef enum logic [1:0] {
    DMA_IDLE  = 2'h0,
    DMA_FETCH = 2'h1,
    DMA_MOVE  = 2'h3
  } dma_state_e;
endpackage

// ### usb_ep_dma.sv
// Endpoint DMA service logic: FIFOs, request channels, interrupts, register slave
// How it works
// - Endpoint zero never gets DMA requests
// - Endpoints one to three: receive and transmit channels
// - Host IN/device OUT receive; others transmit
// - Transmit setting 0 interrupts whenever space frees
// - Transmit setting 1 interrupts on completion, error
// - Auto-arm sends a filled packet without software
// - All DMA traffic uses burst mode
// - DMA interrupts share the single controller vector
// - DMA done and bus done interrupt separately
// - No DMA-complete cause bit; software tracks it
// - Auto-ack releases packet once DMA read it
// - Receive setting 0 interrupts on completion, error
// - Receive setting 1 adds short-packet interrupt
// - Receive DMA reads fixed bytes, writes incrementing, arbitration 64
// - DMA reloads addresses and count, then enables
// - Receive channel may arm early, waits for requests
// - Shared interrupt may mean short, error, transmit
//
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module usb_ep_dma import usb_dma_pkg::*; #(
  parameter int DEPTH = FIFO_DEPTH,
  parameter int PKT   = MAX_PKT
) (
  input  wire logic              clk,
  input  wire logic              reset,
  usb_dma_if.usb_end             dma,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic      [1:0]        s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic      [31:0]       s_axi_rdata,
  output logic      [1:0]        s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   usb_irq,
  output logic      [NUM_EP-1:0] tx_pkt_start,
  input  wire logic              tx_pop,
  input  wire logic [EP_W-1:0]   tx_pop_ep,
  output logic      [7:0]        tx_byte,
  input  wire logic [NUM_EP-1:0] tx_pkt_done,
  input  wire logic [NUM_EP-1:0] usb_err,
  input  wire logic              rx_push,
  input  wire logic [EP_W-1:0]   rx_push_ep,
  input  wire logic [7:0]        rx_byte,
  input  wire logic              rx_end,
  input  wire logic              rx_short,
  output logic      [NUM_EP-1:0] rx_room
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [31:0]       ctrl_reg;
  logic [31:0]       mask_reg;
  logic [31:0]       status_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              rvalid_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        rresp_reg;
  logic [7:0]        tx_byte_reg;
  logic [7:0]        rd_data_reg;
  logic              rd_valid_reg;
  logic [NUM_EP-1:0] cmd_arm;
  logic [NUM_EP-1:0] cmd_ack;
  logic [NUM_EP-1:0] ev_tx;
  logic [NUM_EP-1:0] ev_rx;
  logic [NUM_EP-1:0] armed;
  logic [7:0]        head [NUM_EP];
  logic [31:0]       w1c;
  logic [31:0]       state_word;

  wire host_mode = ctrl_reg[HOST_MODE_BIT];
  wire wr_go     = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
  wire rd_go     = s_axi_arvalid && !rvalid_reg;

  // Endpoint zero maps to no FIFO; its head reads as zero
  function automatic logic [7:0] head_of(input logic [EP_W-1:0] ep);
    logic [7:0] v;
    v = 8'h00;
    for (int k = 0; k < NUM_EP; k++) begin
      if (ep == EP_W'(k + 1)) begin
        v = head[k];
      end
    end
    return v;
  endfunction

  // ****************************************
  // Endpoint FIFOs and packet control
  // ****************************************
  genvar i;
  for (i = 0; i < NUM_EP; i++) begin : g_ep
    localparam int B = i * CTRL_EP_STRIDE;
    logic [7:0]    mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
    logic [CW-1:0] fill;
    logic          ready_q;
    logic          armed_q;
    logic          end_q;
    logic          held_q;
    wire [EP_W-1:0] epn = EP_W'(i + 1);
    wire en       = ctrl_reg[B + DMA_EN_BIT];
    wire is_tx    = ctrl_reg[B + DIR_IN_BIT] ^ host_mode;
    wire tx_mode  = ctrl_reg[B + TX_MODE_BIT];
    wire rx_mode  = ctrl_reg[B + RX_MODE_BIT];
    wire auto_arm = ctrl_reg[B + AUTO_ARM_BIT];
    wire auto_ack = ctrl_reg[B + AUTO_ACK_BIT];
    wire room     = cnt < CW'(DEPTH);
    wire wr_hit   = dma.wr_valid && dma.wr_ep == epn && is_tx;
    wire rd_hit   = dma.rd_strobe && dma.rd_ep == epn && !is_tx;
    // Non-burst accesses are dropped and flagged as errors
    wire dwr      = wr_hit && dma.burst && room;
    wire drd      = rd_hit && dma.burst && cnt != '0;
    wire bad      = (wr_hit || rd_hit) && !dma.burst;
    wire upush    = rx_push && rx_push_ep == epn && rx_room[i];
    wire upop     = tx_pop && tx_pop_ep == epn && is_tx && armed_q && cnt != '0;
    wire push     = is_tx ? dwr : upush;
    wire pop      = is_tx ? upop : drd;
    wire done_hit = dma.done_valid && dma.done_ep == epn;
    wire done_tx  = done_hit && dma.done_tx && is_tx;
    wire done_rx  = done_hit && !dma.done_tx && !is_tx;
    wire arm_now  = ready_q && !armed_q && (auto_arm || cmd_arm[i]);
    wire err      = usb_err[i] || bad;

    always_ff @(posedge clk) begin
      if (push) begin
        mem[wp] <= is_tx ? dma.wr_data : rx_byte;
      end
    end

    always_ff @(posedge clk) begin
      if (reset) begin
        wp  <= '0;
        rp  <= '0;
        cnt <= '0;
      end else begin
        wp  <= push ? AW'(wp + 1'b1) : wp;
        rp  <= pop ? AW'(rp + 1'b1) : rp;
        cnt <= CW'(cnt + CW'(push) - CW'(pop));
      end
    end

    // Transmit packet: fill, ready, armed, sent
    always_ff @(posedge clk) begin
      if (reset) begin
        fill    <= '0;
        ready_q <= 1'b0;
        armed_q <= 1'b0;
        end_q   <= 1'b0;
      end else if (tx_pkt_done[i]) begin
        fill    <= '0;
        ready_q <= 1'b0;
        armed_q <= 1'b0;
        end_q   <= 1'b0;
      end else begin
        fill    <= dwr ? CW'(fill + 1'b1) : fill;
        if ((dwr && fill == CW'(PKT - 1)) || (done_tx && (fill != '0 || dwr))) begin
          ready_q <= 1'b1;
        end
        if (arm_now) begin
          armed_q <= 1'b1;
        end
        if (done_tx) begin
          end_q <= 1'b1;
        end
      end
    end

    // Received packet holds off the next until released
    always_ff @(posedge clk) begin
      if (reset) begin
        held_q <= 1'b0;
      end else if (upush && rx_end) begin
        held_q <= 1'b1;
      end else if (cmd_ack[i] || (held_q && auto_ack && cnt == '0)) begin
        held_q <= 1'b0;
      end
    end

    assign head[i]         = mem[rp];
    assign armed[i]        = armed_q;
    assign tx_pkt_start[i] = arm_now;
    assign dma.tx_req[i]   = en && is_tx && !ready_q && room;
    assign dma.rx_req[i]   = en && !is_tx && cnt != '0;
    assign rx_room[i]      = !is_tx && !held_q && room;
    // Space frees per sent packet; completion-only waits for the last one
    assign ev_tx[i] = err || done_tx || (tx_pkt_done[i] && is_tx &&
                      (tx_mode == DMA_PER_PACKET_IRQ_SETTING || (end_q && cnt == '0)));
    assign ev_rx[i] = err || done_rx || (rx_mode == DMA_COMPLETION_IRQ_SETTING &&
                      upush && rx_end && rx_short);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tx_byte_reg  <= 8'h00;
      rd_data_reg  <= 8'h00;
      rd_valid_reg <= 1'b0;
    end else begin
      if (tx_pop) begin
        tx_byte_reg <= head_of(tx_pop_ep);
      end
      rd_valid_reg <= dma.rd_strobe;
      if (dma.rd_strobe) begin
        rd_data_reg <= head_of(dma.rd_ep);
      end
    end
  end

  // ****************************************
  // Register slave
  // ****************************************
  always_comb begin
    w1c     = 32'h0;
    cmd_arm = '0;
    cmd_ack = '0;
    if (wr_go && s_axi_awaddr == STATUS_OFF) begin
      w1c = s_axi_wdata;
    end
    if (wr_go && s_axi_awaddr == CMD_OFF) begin
      cmd_arm = s_axi_wdata[CMD_ARM_POS +: NUM_EP];
      cmd_ack = s_axi_wdata[CMD_ACK_POS +: NUM_EP];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_reg <= CTRL_RST;
      mask_reg <= MASK_RST;
    end else if (wr_go) begin
      for (int b = 0; b < 4; b++) begin
        if (s_axi_wstrb[b] && s_axi_awaddr == CTRL_OFF) begin
          ctrl_reg[8*b +: 8] <= s_axi_wdata[8*b +: 8];
        end
        if (s_axi_wstrb[b] && s_axi_awaddr == MASK_OFF) begin
          mask_reg[8*b +: 8] <= s_axi_wdata[8*b +: 8];
        end
      end
    end
  end

  // A new event in the clearing cycle survives the write of one
  always_ff @(posedge clk) begin
    if (reset) begin
      status_reg <= STATUS_RST;
    end else begin
      status_reg <= (status_reg & ~w1c) | (32'(ev_tx) << INT_TX_POS) |
                    (32'(ev_rx) << INT_RX_POS);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= (s_axi_awaddr == CTRL_OFF || s_axi_awaddr == CMD_OFF ||
                     s_axi_awaddr == STATUS_OFF || s_axi_awaddr == MASK_OFF) ?
                    RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign state_word = (32'(dma.tx_req) << ST_TXREQ_POS) | (32'(dma.rx_req) << ST_RXREQ_POS) |
                      (32'(armed) << ST_ARMED_POS);

  always_ff @(posedge clk) begin
    if (reset) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0;
      rresp_reg  <= RESP_OKAY;
    end else if (rd_go) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= RESP_OKAY;
      unique case (s_axi_araddr)
        CTRL_OFF:   rdata_reg <= ctrl_reg;
        CMD_OFF:    rdata_reg <= 32'h0;
        STATUS_OFF: rdata_reg <= status_reg;
        MASK_OFF:   rdata_reg <= mask_reg;
        STATE_OFF:  rdata_reg <= state_word;
        default: begin
          rdata_reg <= 32'h0;
          rresp_reg <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign usb_irq       = |(status_reg & mask_reg);
  assign tx_byte       = tx_byte_reg;
  assign dma.rd_data   = rd_data_reg;
  assign dma.rd_valid  = rd_valid_reg;
endmodule // usb_ep_dma
